// >>> logic/pph_port.sv
// Three-port parallel I/O block with strobed handshakes on port C.
// Function
// - Twenty-four lines in three byte ports, each line input or output.
// - Basic mode splits port C into two plain nibble ports, no handshakes.
// - Strobed input: C5 full, C4 strobe, C3 int; C2 strobe, C1 full, C0 int.
// - Strobed output: C7 full_n, C6 ack, C3 int; C2 ack, C1 full_n, C0 int.
// - Bidirectional group A uses C7..C3; C2..C0 follow the group B mode.
// - Strobe, acknowledge and output-full lines are active low.
`timescale 1ns/10ps
module pph_port
(
  // Clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 NRST,
  // Control setting
  input  wire pph_pkg::pph_mode_t   CFG_MODE_A,
  input  wire pph_pkg::pph_mode_t   CFG_MODE_B,
  input  wire logic                 CFG_DIR_A,
  input  wire logic                 CFG_DIR_B,
  input  wire logic                 CFG_DIR_CHI,
  input  wire logic                 CFG_DIR_CLO,
  input  wire logic                 CFG_INTE_A,
  input  wire logic                 CFG_INTE_B,
  // Local data side
  input  wire logic                 WR_A,
  input  wire logic [7:0]           WR_DATA_A,
  input  wire logic                 WR_B,
  input  wire logic [7:0]           WR_DATA_B,
  input  wire logic                 WR_C,
  input  wire logic [7:0]           WR_DATA_C,
  input  wire logic                 RD_A,
  input  wire logic                 RD_B,
  output logic      [7:0]           RD_DATA_A,
  output logic      [7:0]           RD_DATA_B,
  output logic      [7:0]           RD_DATA_C,
  // Port lines
  input  wire logic [7:0]           PORT_A_LINES_I,
  output logic      [7:0]           PORT_A_LINES_O,
  output logic      [7:0]           PORT_A_LINES_OE,
  input  wire logic [7:0]           PORT_B_LINES_I,
  output logic      [7:0]           PORT_B_LINES_O,
  output logic      [7:0]           PORT_B_LINES_OE,
  input  wire logic [7:0]           PORT_C_LINES_I,
  output logic      [7:0]           PORT_C_LINES_O,
  output logic      [7:0]           PORT_C_LINES_OE
);

  import pph_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge history
  // ----------------------------------------------------------------
  logic [23:0] pins_s;
  logic [7:0]  a_s;
  logic [7:0]  b_s;
  logic [7:0]  c_s;
  logic [7:0]  c_prev_ff;

  // Port C history starts at the idle high level of the handshake lines,
  // so leaving reset never looks like a strobe or acknowledge edge.
  pph_sync
  #(
    .WIDTH   (3 * PPH_PORT_W),
    .RST_VAL ({PPH_ALL_ON, PPH_BYTE_RST, PPH_BYTE_RST})
  )
  u_sync
  (
    .clk      (MCLK),
    .rst_n    (NRST),
    .async_in ({PORT_C_LINES_I, PORT_B_LINES_I, PORT_A_LINES_I}),
    .sync_out (pins_s)
  );

  assign a_s = pins_s[7:0];
  assign b_s = pins_s[15:8];
  assign c_s = pins_s[23:16];

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      c_prev_ff <= PPH_ALL_ON;
    else
      c_prev_ff <= c_s;
  end

  // ----------------------------------------------------------------
  // Handshake events
  // ----------------------------------------------------------------
  logic in_en_a;
  logic out_en_a;
  logic in_en_b;
  logic out_en_b;
  logic strb_fall_a;
  logic strb_rise_a;
  logic ack_fall_a;
  logic ack_rise_a;
  logic strb_fall_b;
  logic strb_rise_b;
  logic ack_fall_b;
  logic ack_rise_b;

  assign in_en_a  = (CFG_MODE_A == PPH_HS_IN) || (CFG_MODE_A == PPH_BIDIR);
  assign out_en_a = (CFG_MODE_A == PPH_HS_OUT) || (CFG_MODE_A == PPH_BIDIR);
  assign in_en_b  = (CFG_MODE_B == PPH_HS_IN);
  assign out_en_b = (CFG_MODE_B == PPH_HS_OUT);

  // Strobe and acknowledge assert low, so a falling level starts them.
  assign strb_fall_a = in_en_a & c_prev_ff[PPH_C_STRB_A]
                     & ~c_s[PPH_C_STRB_A];
  assign strb_rise_a = in_en_a & ~c_prev_ff[PPH_C_STRB_A]
                     & c_s[PPH_C_STRB_A];
  assign ack_fall_a  = out_en_a & c_prev_ff[PPH_C_ACK_A]
                     & ~c_s[PPH_C_ACK_A];
  assign ack_rise_a  = out_en_a & ~c_prev_ff[PPH_C_ACK_A]
                     & c_s[PPH_C_ACK_A];
  assign strb_fall_b = in_en_b & c_prev_ff[PPH_C_HSK_B] & ~c_s[PPH_C_HSK_B];
  assign strb_rise_b = in_en_b & ~c_prev_ff[PPH_C_HSK_B] & c_s[PPH_C_HSK_B];
  assign ack_fall_b = out_en_b & c_prev_ff[PPH_C_HSK_B] & ~c_s[PPH_C_HSK_B];
  assign ack_rise_b = out_en_b & ~c_prev_ff[PPH_C_HSK_B] & c_s[PPH_C_HSK_B];

  // ----------------------------------------------------------------
  // Group A buffers and flags
  // ----------------------------------------------------------------
  logic [7:0] a_in_ff;
  logic [7:0] a_out_ff;
  logic       a_ifull_ff;
  logic       a_ofull_ff;
  logic       a_int_ff;

  // Every flag below lets its setting event win over a same-cycle clear.
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      a_in_ff    <= PPH_BYTE_RST;
      a_out_ff   <= PPH_BYTE_RST;
      a_ifull_ff <= 1'b0;
      a_ofull_ff <= 1'b0;
      a_int_ff   <= 1'b0;
    end
    else
    begin
      if (strb_fall_a)
        a_in_ff <= a_s;
      if (WR_A)
        a_out_ff <= WR_DATA_A;
      a_ifull_ff <= strb_fall_a | (a_ifull_ff & ~RD_A);
      a_ofull_ff <= (WR_A & out_en_a) | (a_ofull_ff & ~ack_fall_a);
      a_int_ff   <= (CFG_INTE_A & (strb_rise_a | ack_rise_a))
                  | (a_int_ff & ~(RD_A & in_en_a) & ~(WR_A & out_en_a));
    end
  end

  // ----------------------------------------------------------------
  // Group B buffers and flags
  // ----------------------------------------------------------------
  logic [7:0] b_in_ff;
  logic [7:0] b_out_ff;
  logic [7:0] c_wr_ff;
  logic       b_full_ff;
  logic       b_int_ff;

  // One full flag serves both directions since group B has no bidirectional mode.
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      b_in_ff   <= PPH_BYTE_RST;
      b_out_ff  <= PPH_BYTE_RST;
      c_wr_ff   <= PPH_BYTE_RST;
      b_full_ff <= 1'b0;
      b_int_ff  <= 1'b0;
    end
    else
    begin
      if (strb_fall_b)
        b_in_ff <= b_s;
      if (WR_B)
        b_out_ff <= WR_DATA_B;
      if (WR_C)
        c_wr_ff <= WR_DATA_C;
      b_full_ff <= strb_fall_b | (WR_B & out_en_b)
                 | (b_full_ff & ~(RD_B & in_en_b) & ~ack_fall_b);
      b_int_ff  <= (CFG_INTE_B & (strb_rise_b | ack_rise_b))
                 | (b_int_ff & ~(RD_B & in_en_b) & ~(WR_B & out_en_b));
    end
  end

  // ----------------------------------------------------------------
  // Pin drive selection
  // ----------------------------------------------------------------
  logic [7:0] nxt_a_oe;
  logic [7:0] nxt_b_oe;
  logic [7:0] nxt_c_o;
  logic [7:0] nxt_c_oe;

  always_comb
  begin
    case (CFG_MODE_A)
      PPH_BASIC:   nxt_a_oe = {8{CFG_DIR_A}};
      PPH_HS_OUT:  nxt_a_oe = PPH_ALL_ON;
      // Bidirectional port A drives only while the peer acknowledges.
      PPH_BIDIR:   nxt_a_oe = {8{~c_s[PPH_C_ACK_A]}};
      default:     nxt_a_oe = PPH_ALL_OFF;
    endcase
    case (CFG_MODE_B)
      PPH_HS_IN:   nxt_b_oe = PPH_ALL_OFF;
      PPH_HS_OUT:  nxt_b_oe = PPH_ALL_ON;
      default:     nxt_b_oe = {8{CFG_DIR_B}};
    endcase
  end

  always_comb
  begin
    nxt_c_o  = c_wr_ff;
    nxt_c_oe = {{PPH_NIB_W{CFG_DIR_CHI}}, {PPH_NIB_W{CFG_DIR_CLO}}};
    case (CFG_MODE_A)
      PPH_HS_IN:
      begin
        nxt_c_o[PPH_C_IFULL_A]  = a_ifull_ff;
        nxt_c_oe[PPH_C_IFULL_A] = 1'b1;
        nxt_c_oe[PPH_C_STRB_A]  = 1'b0;
        nxt_c_o[PPH_C_INT_A]    = a_int_ff;
        nxt_c_oe[PPH_C_INT_A]   = 1'b1;
      end
      PPH_HS_OUT:
      begin
        nxt_c_o[PPH_C_OFULL_A]  = ~a_ofull_ff;
        nxt_c_oe[PPH_C_OFULL_A] = 1'b1;
        nxt_c_oe[PPH_C_ACK_A]   = 1'b0;
        nxt_c_o[PPH_C_INT_A]    = a_int_ff;
        nxt_c_oe[PPH_C_INT_A]   = 1'b1;
      end
      PPH_BIDIR:
      begin
        nxt_c_o[PPH_C_OFULL_A]  = ~a_ofull_ff;
        nxt_c_oe[PPH_C_OFULL_A] = 1'b1;
        nxt_c_oe[PPH_C_ACK_A]   = 1'b0;
        nxt_c_o[PPH_C_IFULL_A]  = a_ifull_ff;
        nxt_c_oe[PPH_C_IFULL_A] = 1'b1;
        nxt_c_oe[PPH_C_STRB_A]  = 1'b0;
        nxt_c_o[PPH_C_INT_A]    = a_int_ff;
        nxt_c_oe[PPH_C_INT_A]   = 1'b1;
      end
      default:
      begin
        nxt_c_o[PPH_C_INT_A] = c_wr_ff[PPH_C_INT_A];
      end
    endcase
    case (CFG_MODE_B)
      PPH_HS_IN:
      begin
        nxt_c_oe[PPH_C_HSK_B]  = 1'b0;
        nxt_c_o[PPH_C_FULL_B]  = b_full_ff;
        nxt_c_oe[PPH_C_FULL_B] = 1'b1;
        nxt_c_o[PPH_C_INT_B]   = b_int_ff;
        nxt_c_oe[PPH_C_INT_B]  = 1'b1;
      end
      PPH_HS_OUT:
      begin
        nxt_c_oe[PPH_C_HSK_B]  = 1'b0;
        nxt_c_o[PPH_C_FULL_B]  = ~b_full_ff;
        nxt_c_oe[PPH_C_FULL_B] = 1'b1;
        nxt_c_o[PPH_C_INT_B]   = b_int_ff;
        nxt_c_oe[PPH_C_INT_B]  = 1'b1;
      end
      default:
      begin
        nxt_c_o[PPH_C_INT_B] = c_wr_ff[PPH_C_INT_B];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PORT_A_LINES_O  <= PPH_BYTE_RST;
      PORT_A_LINES_OE <= PPH_ALL_OFF;
      PORT_B_LINES_O  <= PPH_BYTE_RST;
      PORT_B_LINES_OE <= PPH_ALL_OFF;
      PORT_C_LINES_O  <= PPH_BYTE_RST;
      PORT_C_LINES_OE <= PPH_ALL_OFF;
      RD_DATA_A       <= PPH_BYTE_RST;
      RD_DATA_B       <= PPH_BYTE_RST;
      RD_DATA_C       <= PPH_BYTE_RST;
    end
    else
    begin
      PORT_A_LINES_O  <= a_out_ff;
      PORT_A_LINES_OE <= nxt_a_oe;
      PORT_B_LINES_O  <= b_out_ff;
      PORT_B_LINES_OE <= nxt_b_oe;
      PORT_C_LINES_O  <= nxt_c_o;
      PORT_C_LINES_OE <= nxt_c_oe;
      RD_DATA_A       <= in_en_a ? a_in_ff : a_s;
      RD_DATA_B       <= in_en_b ? b_in_ff : b_s;
      RD_DATA_C       <= c_s;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  port_b_dir_a: assert property (
    CFG_MODE_B == PPH_BASIC |=> PORT_B_LINES_OE == {8{$past(CFG_DIR_B)}})
    else $error("Port B direction does not follow its setting.");

  c_nibbles_a: assert property (
    CFG_MODE_A == PPH_BASIC && CFG_MODE_B == PPH_BASIC
    |=> PORT_C_LINES_OE == {{4{$past(CFG_DIR_CHI)}}, {4{$past(CFG_DIR_CLO)}}})
    else $error("Port C nibbles do not follow their directions.");

  in_full_a: assert property (
    strb_fall_a && CFG_MODE_A == PPH_HS_IN ##1 CFG_MODE_A == PPH_HS_IN
    |=> PORT_C_LINES_O[PPH_C_IFULL_A] && PORT_C_LINES_OE[PPH_C_IFULL_A])
    else $error("Group A input full not shown after strobe.");

  out_full_a: assert property (
    WR_A && CFG_MODE_A == PPH_HS_OUT ##1 CFG_MODE_A == PPH_HS_OUT
    |=> !PORT_C_LINES_O[PPH_C_OFULL_A])
    else $error("Group A output full not driven low after write.");

  bidir_map_a: assert property (
    CFG_MODE_A == PPH_BIDIR |=> !PORT_C_LINES_OE[PPH_C_ACK_A]
      && !PORT_C_LINES_OE[PPH_C_STRB_A] && PORT_C_LINES_OE[PPH_C_INT_A]
      && PORT_A_LINES_OE == {8{~$past(c_s[PPH_C_ACK_A])}})
    else $error("Bidirectional group A pin map wrong.");

  ack_release_a: assert property (
    ack_fall_a && !WR_A && CFG_MODE_A == PPH_HS_OUT
    ##1 CFG_MODE_A == PPH_HS_OUT
    |=> PORT_C_LINES_O[PPH_C_OFULL_A])
    else $error("Output full not released after acknowledge.");

  mode_apply_a: assert property (
    $changed(CFG_MODE_B) && CFG_MODE_B == PPH_HS_IN
    |=> !PORT_C_LINES_OE[PPH_C_HSK_B] && PORT_C_LINES_OE[PPH_C_FULL_B]
      && PORT_B_LINES_OE == PPH_ALL_OFF)
    else $error("Group B mode change not applied in one cycle.");

  b_int_a: assert property (
    strb_rise_b && CFG_INTE_B ##1 CFG_MODE_B == PPH_HS_IN && !RD_B
    |=> PORT_C_LINES_O[PPH_C_INT_B])
    else $error("Group B interrupt not raised after strobe.");

  cov_strobe_in: cover property (strb_fall_a ##[1:20] RD_A);
  cov_ack_out:   cover property (WR_A && out_en_a ##[1:20] ack_fall_a);
  cov_bidir:     cover property (CFG_MODE_A == PPH_BIDIR && strb_fall_a);
  cov_int_b:     cover property (strb_rise_b && CFG_INTE_B);

endmodule

// >>> logic/pph_pkg.sv
// Constants and types shared by the parallel port handshake block.
package pph_pkg;

  // ----------------------------------------------------------------
  // Port geometry and reset values
  // ----------------------------------------------------------------
  localparam int         PPH_PORT_W    = 8;
  localparam int         PPH_NIB_W     = 4;
  localparam logic [7:0] PPH_BYTE_RST  = 8'h00;
  localparam logic [7:0] PPH_ALL_ON    = 8'hFF;
  localparam logic [7:0] PPH_ALL_OFF   = 8'h00;

  // ----------------------------------------------------------------
  // Port C bit positions of the handshake functions
  // ----------------------------------------------------------------
  localparam int PPH_C_OFULL_A = 7;
  localparam int PPH_C_ACK_A   = 6;
  localparam int PPH_C_IFULL_A = 5;
  localparam int PPH_C_STRB_A  = 4;
  localparam int PPH_C_INT_A   = 3;
  localparam int PPH_C_HSK_B   = 2;
  localparam int PPH_C_FULL_B  = 1;
  localparam int PPH_C_INT_B   = 0;

  // ----------------------------------------------------------------
  // Group modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PPH_BASIC  = 2'b00,
    PPH_HS_IN  = 2'b01,
    PPH_HS_OUT = 2'b10,
    PPH_BIDIR  = 2'b11
  } pph_mode_t;

endpackage

// >>> logic/pph_sync.sv
// Two-stage synchroniser for a bus of independent pin levels.
`timescale 1ns/10ps
module pph_sync
#(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // Elaboration stops on a width the logic cannot serve.
  if (WIDTH < 1)
  begin : g_width_check
    $error("pph_sync: WIDTH must be at least one.");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff  <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// >>> sim/pph_periph.sv
// Model of the external peripheral that strobes and acknowledges bytes.
`timescale 1ns/10ps
module pph_periph
(
  // Clock
  input  wire logic       clk,
  // Device side of the pins
  input  wire logic [7:0] a_o,
  input  wire logic [7:0] a_oe,
  input  wire logic [7:0] b_o,
  input  wire logic [7:0] b_oe,
  input  wire logic [7:0] c_o,
  input  wire logic [7:0] c_oe,
  // Resolved pin levels
  output logic      [7:0] a_i,
  output logic      [7:0] b_i,
  output logic      [7:0] c_i
);
  logic [7:0] a_drv = 8'h00;
  logic [7:0] b_drv = 8'h00;
  // Handshake lines rest high, their inactive level.
  logic [7:0] c_drv = 8'hFF;

  assign a_i = (a_oe & a_o) | (~a_oe & a_drv);
  assign b_i = (b_oe & b_o) | (~b_oe & b_drv);
  assign c_i = (c_oe & c_o) | (~c_oe & c_drv);

  // Byte on port A or B, strobe low 3 cycles; data is lost after the rise.
  task automatic strobe(input int bt, input bit on_b, input logic [7:0] d);
    if (on_b)
      b_drv = d;
    else
      a_drv = d;
    @(negedge clk);
    c_drv[bt] = 1'b0;
    repeat (3) @(negedge clk);
    c_drv[bt] = 1'b1;
    if (on_b)
      b_drv = ~d;
    else
      a_drv = ~d;
    repeat (3) @(negedge clk);
  endtask

  // Acknowledge pulse, low 4 cycles then high 4 cycles.
  task automatic ack(input int bt);
    c_drv[bt] = 1'b0;
    repeat (4) @(negedge clk);
    c_drv[bt] = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule

// >>> sim/parallel_port_handshake_tb.sv
// Self-checking bench for the parallel port handshake block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module parallel_port_handshake_tb;
  import pph_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  pph_mode_t mode_a = PPH_BASIC;
  pph_mode_t mode_b = PPH_BASIC;
  logic dir_a = 0, dir_b = 0, dir_chi = 0, dir_clo = 0;
  logic inte_a = 0, inte_b = 0, wr_a = 0, wr_b = 0, wr_c = 0;
  logic rd_a = 0, rd_b = 0;
  logic [7:0] wd_a = 8'h00, wd_b = 8'h00, wd_c = 8'h00;
  logic [7:0] rda, rdb, rdc, a_i, a_o, a_oe, b_i, b_o, b_oe, c_i, c_o, c_oe;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  always #2.5 mclk = ~mclk;

  pph_port dut (.MCLK(mclk), .NRST(nrst), .CFG_MODE_A(mode_a),
    .CFG_MODE_B(mode_b), .CFG_DIR_A(dir_a), .CFG_DIR_B(dir_b),
    .CFG_DIR_CHI(dir_chi), .CFG_DIR_CLO(dir_clo), .CFG_INTE_A(inte_a),
    .CFG_INTE_B(inte_b), .WR_A(wr_a), .WR_DATA_A(wd_a), .WR_B(wr_b),
    .WR_DATA_B(wd_b), .WR_C(wr_c), .WR_DATA_C(wd_c), .RD_A(rd_a),
    .RD_B(rd_b), .RD_DATA_A(rda), .RD_DATA_B(rdb), .RD_DATA_C(rdc),
    .PORT_A_LINES_I(a_i), .PORT_A_LINES_O(a_o), .PORT_A_LINES_OE(a_oe),
    .PORT_B_LINES_I(b_i), .PORT_B_LINES_O(b_o), .PORT_B_LINES_OE(b_oe),
    .PORT_C_LINES_I(c_i), .PORT_C_LINES_O(c_o), .PORT_C_LINES_OE(c_oe));

  pph_periph per (.clk(mclk), .a_o(a_o), .a_oe(a_oe), .b_o(b_o),
    .b_oe(b_oe), .c_o(c_o), .c_oe(c_oe), .a_i(a_i), .b_i(b_i), .c_i(c_i));

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Bounded wait for a port C pin level; the caller compares afterwards.
  task automatic wait_c(input int bt, input logic v);
    int k;
    k = 0;
    while (c_o[bt] !== v && k < 40)
    begin
      cyc(1);
      k++;
    end
  endtask

  task automatic t_basic;
    dir_a = 1; dir_chi = 1; per.b_drv = 8'h5A;
    wd_a = 8'hC3; wd_c = 8'hB5; wr_a = 1; wr_c = 1;
    cyc(1);
    wr_a = 0; wr_c = 0;
    cyc(3);
    `CHK("a_oe", 8'hFF, a_oe)
    `CHK("a_o", 8'hC3, a_o)
    `CHK("b_oe", 8'h00, b_oe)
    `CHK("c_oe", 8'hF0, c_oe)
    `CHK("c_hi", 4'hB, c_o[7:4])
    rd_b = 1;
    cyc(1);
    rd_b = 0;
    cyc(1);
    `CHK("rdb", 8'h5A, rdb)
    `CHK("rdc_lo", 4'hF, rdc[3:0])
    dir_a = 0; dir_chi = 0;
    cyc(2);
    `CHK("a_oe off", 8'h00, a_oe)
    $display("test basic done");
  endtask

  task automatic t_strobe_in;
    mode_a = PPH_HS_IN; mode_b = PPH_HS_IN; inte_a = 1;
    cyc(2);
    `CHK("c_oe in", 6'b101011, c_oe[5:0])
    `CHK("full idle", 1'b0, c_o[5])
    `CHK("int idle", 1'b0, c_o[3])
    per.strobe(4, 0, 8'h96);
    wait_c(5, 1);
    `CHK("full a", 1'b1, c_o[5])
    wait_c(3, 1);
    `CHK("int a", 1'b1, c_o[3])
    rd_a = 1;
    cyc(1);
    rd_a = 0;
    cyc(3);
    `CHK("rda", 8'h96, rda)
    `CHK("full+int a clr", 2'b00, {c_o[5], c_o[3]})
    per.strobe(2, 1, 8'h3E);
    wait_c(1, 1);
    `CHK("full b", 1'b1, c_o[1])
    `CHK("int b masked", 1'b0, c_o[0])
    rd_b = 1;
    cyc(1);
    rd_b = 0;
    cyc(3);
    `CHK("rdb", 8'h3E, rdb)
    inte_b = 1;
    per.strobe(2, 1, 8'hC7);
    wait_c(0, 1);
    `CHK("int b", 1'b1, c_o[0])
    rd_b = 1;
    cyc(1);
    rd_b = 0;
    inte_b = 0;
    cyc(3);
    `CHK("rdb 2", 8'hC7, rdb)
    `CHK("full+int b clr", 2'b00, {c_o[1], c_o[0]})
    $display("test strobe in done");
  endtask

  task automatic t_strobe_out;
    mode_a = PPH_HS_OUT; mode_b = PPH_HS_OUT;
    cyc(2);
    `CHK("c_oe out", 5'b10_011, {c_oe[7:6], c_oe[2:0]})
    `CHK("full_n idle", 2'b11, {c_o[7], c_o[1]})
    wd_a = 8'h3C; wd_b = 8'hE1; wr_a = 1; wr_b = 1;
    cyc(1);
    wr_a = 0; wr_b = 0;
    wait_c(7, 0);
    `CHK("full_n a", 1'b0, c_o[7])
    `CHK("a_o", 8'h3C, a_o)
    `CHK("full_n b", 1'b0, c_o[1])
    `CHK("b_o", 8'hE1, b_o)
    `CHK("b_oe out", 8'hFF, b_oe)
    per.ack(6);
    per.ack(2);
    `CHK("full_n clr", 2'b11, {c_o[7], c_o[1]})
    `CHK("int a", 1'b1, c_o[3])
    `CHK("int b masked", 1'b0, c_o[0])
    wr_a = 1;
    cyc(1);
    wr_a = 0;
    cyc(3);
    `CHK("int a clr", 1'b0, c_o[3])
    per.ack(6);
    $display("test strobe out done");
  endtask

  task automatic t_bidir;
    mode_a = PPH_BIDIR; mode_b = PPH_BIDIR; dir_clo = 1;
    wd_c = 8'h05; wr_c = 1;
    cyc(1);
    wr_c = 0;
    cyc(3);
    `CHK("c_oe bidir", 8'hAF, c_oe)
    `CHK("c_lo", 3'b101, c_o[2:0])
    `CHK("a_oe idle", 8'h00, a_oe)
    per.strobe(4, 0, 8'h71);
    wait_c(5, 1);
    rd_a = 1;
    cyc(1);
    rd_a = 0;
    cyc(2);
    `CHK("rda", 8'h71, rda)
    wd_a = 8'h5C;
    wr_a = 1;
    cyc(1);
    wr_a = 0;
    cyc(2);
    `CHK("full_n bidir", 1'b0, c_o[7])
    per.c_drv[6] = 1'b0;
    cyc(4);
    `CHK("a_oe bidir", 8'hFF, a_oe)
    `CHK("a_i bidir", 8'h5C, a_i)
    per.c_drv[6] = 1'b1;
    cyc(4);
    `CHK("a_oe released", 8'h00, a_oe)
    `CHK("full_n bidir clr", 1'b1, c_o[7])
    $display("test bidir done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    cyc(12);
    nrst = 1;
    cyc(1);
    t_basic();
    t_strobe_in();
    t_strobe_out();
    t_bidir();
    report_and_stop();
  end
endmodule
